// File: design/cwd_defines.svh
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH

`define CWD_ADDR_W           16
`define CWD_DATA_W           16
`define CWD_OFF_MULTIPLIER   16'h0400
`define CWD_OFF_LI_TIMER     16'h0410
`define CWD_OFF_SM_TIMER     16'h0420
`define CWD_OFF_STATUS       16'h0440
`define CWD_RST_MULTIPLIER   16'h09c2
`define CWD_RST_SM_TIMER     16'h03e8
`define CWD_RST_LI_TIMER     16'h03e8
`define CWD_STAT_SM_BIT      0
`define CWD_STAT_LI_BIT      1
`define CWD_CLK_PERIOD_PS    25000
`define CWD_BASE_TICK_PS     40000
`define CWD_MULT_OFFSET      2

`endif

// File: design/cwd_pkg.sv
package cwd_pkg;

  typedef enum logic [2:0] {
    CWD_ST_INIT          = 3'b000,
    CWD_ST_PREOP         = 3'b001,
    CWD_ST_SAFEOP        = 3'b010,
    CWD_ST_RUNNING_STATE = 3'b011,
    CWD_ST_BOOT          = 3'b100
  } cwd_comm_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cwd_reg_req_s;

  typedef struct packed {
    logic        rvalid;
    logic [15:0] rdata;
  } cwd_reg_rsp_s;

endpackage

// File: design/cwd_top.sv
`timescale 1ns/1ps
`include "cwd_defines.svh"

// Function
// - Each completed fieldbus process data exchange restarts the sync manager watchdog.
// - Sync manager watchdog triggers after silence longer than its enabled time.
// - A trigger leaves the communication state unchanged, usually running.
// - A triggered sync manager watchdog clears on a new process data access or when its timer is set to zero.
// - Local interface watchdog triggers after local silence longer than its time.
// - A triggered watchdog drives outputs to a preset safe value.
// - One multiplier register at 0x0400 sets the prescaler of both watchdogs.
// - Timers at 0x0410 (local) and 0x0420 (sync manager), combined with multiplier.
// - Watchdog tick is multiplier plus two base ticks of 40 ns.
// - Defaults are multiplier 2498 and timers 1000, giving 100 ms.
// - A zero sync manager timer disables it; outputs are then forced only by the local interface watchdog.
module cwd_top #(
  parameter int                OUT_W      = 8,
  parameter logic [OUT_W-1:0]  SAFE_VALUE = '0
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  input  wire cwd_pkg::cwd_reg_req_s    i_reg_req,
  output cwd_pkg::cwd_reg_rsp_s         o_reg_rsp,
  input  wire logic                     i_pd_exchange_done,
  input  wire logic                     i_local_access,
  input  wire cwd_pkg::cwd_comm_state_e i_comm_state,
  output cwd_pkg::cwd_comm_state_e      o_comm_state,
  input  wire logic [OUT_W-1:0]         i_app_outputs,
  output logic [OUT_W-1:0]              o_outputs,
  output logic                          o_sm_expired,
  output logic                          o_li_expired
);

  localparam logic [7:0] BASE_STEP =
    8'(`CWD_CLK_PERIOD_PS / 1000);
  localparam logic [7:0] BASE_MOD  =
    8'(`CWD_BASE_TICK_PS / 1000);

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  logic [15:0]             mult_reg;
  logic [15:0]             mult_next;
  logic [15:0]             li_timer_reg;
  logic [15:0]             li_timer_next;
  logic [15:0]             sm_timer_reg;
  logic [15:0]             sm_timer_next;
  cwd_pkg::cwd_reg_rsp_s   rsp_reg;
  cwd_pkg::cwd_reg_rsp_s   rsp_next;
  logic [7:0]              acc_reg;
  logic [7:0]              acc_next;
  logic                    base_tick_reg;
  logic                    base_tick_next;
  logic                    sm_exp;
  logic                    li_exp;
  logic [OUT_W-1:0]        out_reg;
  logic [OUT_W-1:0]        out_next;
  logic                    sm_flag_reg;
  logic                    li_flag_reg;
  cwd_pkg::cwd_comm_state_e state_reg;

  // Register file
  always_comb begin
    mult_next     = mult_reg;
    li_timer_next = li_timer_reg;
    sm_timer_next = sm_timer_reg;
    rsp_next      = '0;
    if (i_reg_req.wr) begin
      if (hit(i_reg_req.addr, `CWD_OFF_MULTIPLIER)) begin
        mult_next = i_reg_req.wdata;
      end
      if (hit(i_reg_req.addr, `CWD_OFF_LI_TIMER)) begin
        li_timer_next = i_reg_req.wdata;
      end
      if (hit(i_reg_req.addr, `CWD_OFF_SM_TIMER)) begin
        sm_timer_next = i_reg_req.wdata;
      end
    end
    if (i_reg_req.rd) begin
      rsp_next.rvalid = 1'b1;
      if (hit(i_reg_req.addr, `CWD_OFF_MULTIPLIER)) begin
        rsp_next.rdata = mult_reg;
      end else if (hit(i_reg_req.addr, `CWD_OFF_LI_TIMER)) begin
        rsp_next.rdata = li_timer_reg;
      end else if (hit(i_reg_req.addr, `CWD_OFF_SM_TIMER)) begin
        rsp_next.rdata = sm_timer_reg;
      end else if (hit(i_reg_req.addr, `CWD_OFF_STATUS)) begin
        rsp_next.rdata[`CWD_STAT_SM_BIT] = sm_flag_reg;
        rsp_next.rdata[`CWD_STAT_LI_BIT] = li_flag_reg;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mult_reg     <= `CWD_RST_MULTIPLIER;
      li_timer_reg <= `CWD_RST_LI_TIMER;
      sm_timer_reg <= `CWD_RST_SM_TIMER;
      rsp_reg      <= '0;
    end else begin
      mult_reg     <= mult_next;
      li_timer_reg <= li_timer_next;
      sm_timer_reg <= sm_timer_next;
      rsp_reg      <= rsp_next;
    end
  end

  // 25 MHz base tick from the 40 MHz clock: a phase accumulator, so ticks
  // jitter by one clock but the long-run rate is exact
  always_comb begin
    if (acc_reg + BASE_STEP >= BASE_MOD) begin
      acc_next       = acc_reg + BASE_STEP - BASE_MOD;
      base_tick_next = 1'b1;
    end else begin
      acc_next       = acc_reg + BASE_STEP;
      base_tick_next = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc_reg       <= 8'h00;
      base_tick_reg <= 1'b0;
    end else begin
      acc_reg       <= acc_next;
      base_tick_reg <= base_tick_next;
    end
  end

  cwd_wd_timer u_sm_wd (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_base_tick  (base_tick_reg),
    .i_multiplier (mult_reg),
    .i_timer      (sm_timer_reg),
    .i_restart    (i_pd_exchange_done),
    .o_expired    (sm_exp)
  );

  cwd_wd_timer u_li_wd (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_base_tick  (base_tick_reg),
    .i_multiplier (mult_reg),
    .i_timer      (li_timer_reg),
    .i_restart    (i_local_access),
    .o_expired    (li_exp)
  );

  // Safe output gating; the state machine input is only passed along
  always_comb begin
    out_next = (sm_exp || li_exp) ? SAFE_VALUE : i_app_outputs;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      out_reg     <= SAFE_VALUE;
      sm_flag_reg <= 1'b0;
      li_flag_reg <= 1'b0;
      state_reg   <= cwd_pkg::CWD_ST_INIT;
    end else begin
      out_reg     <= out_next;
      sm_flag_reg <= sm_exp;
      li_flag_reg <= li_exp;
      state_reg   <= i_comm_state;
    end
  end

  assign o_reg_rsp    = rsp_reg;
  assign o_outputs    = out_reg;
  assign o_sm_expired = sm_flag_reg;
  assign o_li_expired = li_flag_reg;
  assign o_comm_state = state_reg;

  safe_outputs_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (sm_exp || li_exp) |=> (o_outputs == SAFE_VALUE))
    else $error("outputs not forced to safe value");

  pass_through_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (!sm_exp && !li_exp) |=> (o_outputs == $past(i_app_outputs)))
    else $error("outputs not passed while healthy");

  mult_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_reg_req.wr && i_reg_req.addr == `CWD_OFF_MULTIPLIER)
      |=> (mult_reg == $past(i_reg_req.wdata)))
    else $error("multiplier write lost");

  timer_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_reg_req.wr && i_reg_req.addr == `CWD_OFF_SM_TIMER)
      |=> (sm_timer_reg == $past(i_reg_req.wdata) && $stable(li_timer_reg)))
    else $error("timer write misrouted");

  reset_values_a: assert property (@(posedge i_clock)
    $past(i_rst) |-> (mult_reg == `CWD_RST_MULTIPLIER && sm_timer_reg == `CWD_RST_SM_TIMER))
    else $error("wrong default watchdog settings");

  base_rate_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (!base_tick_reg [*2]) |=> base_tick_reg)
    else $error("base tick slower than 25 MHz");

  zero_disables_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (sm_timer_reg == 16'h0000 && $past(sm_timer_reg) == 16'h0000) |=> !o_sm_expired)
    else $error("disabled watchdog reported expiry");

  li_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_reg_req.wr && i_reg_req.addr == `CWD_OFF_LI_TIMER)
      |=> (li_timer_reg == $past(i_reg_req.wdata) && $stable(sm_timer_reg)))
    else $error("local timer write misrouted");

  state_kept_a: assert property (@(posedge i_clock) disable iff (i_rst)
    sm_exp |=> (o_comm_state == $past(i_comm_state)))
    else $error("expiry changed communication state");

  sm_expiry_c: cover property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_sm_expired));
  li_expiry_c: cover property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_li_expired));
  sm_recover_c: cover property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_sm_expired));
  zero_timer_c: cover property (@(posedge i_clock) disable iff (i_rst)
    i_reg_req.wr && i_reg_req.addr == `CWD_OFF_SM_TIMER && i_reg_req.wdata == 16'h0000);

endmodule // cwd_top

// File: design/cwd_wd_timer.sv
`timescale 1ns/1ps
`include "cwd_defines.svh"

module cwd_wd_timer (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_base_tick,
  input  wire logic [15:0] i_multiplier,
  input  wire logic [15:0] i_timer,
  input  wire logic        i_restart,
  output logic             o_expired
);

  logic [16:0] pre_reg;
  logic [16:0] pre_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        exp_reg;
  logic        exp_next;
  logic [16:0] pre_limit;
  logic        wd_tick;

  // One watchdog tick spans multiplier plus two base ticks
  assign pre_limit = {1'b0, i_multiplier} + 17'(`CWD_MULT_OFFSET - 1);
  assign wd_tick   = i_base_tick && (pre_reg >= pre_limit);

  always_comb begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    exp_next = exp_reg;
    if (i_restart) begin
      pre_next = 17'h00000;
      cnt_next = 16'h0000;
      exp_next = 1'b0;
    end else begin
      if (i_base_tick) begin
        pre_next = wd_tick ? 17'h00000 : pre_reg + 17'h00001;
      end
      if (wd_tick && cnt_reg != 16'hffff) begin
        cnt_next = cnt_reg + 16'h0001;
      end
      // Zero timer blocks expiry, so a stale expiry is dropped too; prescaler and counter keep running
      if (i_timer == 16'h0000) begin
        exp_next = 1'b0;
      end else if (cnt_reg >= i_timer) begin
        exp_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pre_reg <= 17'h00000;
      cnt_reg <= 16'h0000;
      exp_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign o_expired = exp_reg;

  restart_clears_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_restart |=> (!exp_reg && cnt_reg == 16'h0000 && pre_reg == 17'h00000))
    else $error("restart did not clear watchdog");

  expire_limit_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (!i_restart && i_timer != 16'h0000 && cnt_reg >= i_timer) |=> exp_reg)
    else $error("watchdog failed to expire at limit");

  expired_sticky_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (exp_reg && !i_restart && i_timer != 16'h0000) |=> exp_reg)
    else $error("expiry cleared without an access");

  prescale_wrap_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (wd_tick && !i_restart) |=> (pre_reg == 17'h00000 && cnt_reg != 16'h0000))
    else $error("prescaler did not wrap into a watchdog tick");

endmodule // cwd_wd_timer

// File: verif/cwd_partner.sv
`timescale 1ns/1ps

module cwd_partner #(
  parameter int GAP = 4
) (
  input  wire logic i_clock,
  input  wire logic i_run,
  input  wire logic i_kick,
  output logic      o_pulse
);
  int   cnt = 0;
  logic kick;

  initial o_pulse = 1'b0;

  // Exchanges come one cycle wide, paced well inside the watchdog time
  always @(posedge i_clock) begin
    kick = i_kick;
    #1;
    cnt = (cnt + 1) % GAP;
    o_pulse = kick || (i_run && cnt == 0);
  end
endmodule // cwd_partner

// File: verif/cwd_top_tb.sv
`timescale 1ns/1ps

module cwd_top_tb;
  logic                  i_clock = 1'b0;
  logic                  i_rst   = 1'b1;
  cwd_pkg::cwd_reg_req_s req     = '0;
  cwd_pkg::cwd_reg_rsp_s rsp;
  cwd_pkg::cwd_comm_state_e st_out;
  cwd_pkg::cwd_comm_state_e st_in = cwd_pkg::CWD_ST_RUNNING_STATE;
  logic       pd_run = 1'b0, pd_kick = 1'b0, li_kick = 1'b0, rnd_on = 1'b1;
  logic       pd_pulse, li_pulse, sm_exp, li_exp;
  logic [7:0] app = 8'h00, outs;
  logic [31:0] seed = 32'h0106;
  int         n_errors = 0, checked = 0, n;

  always #12.5 i_clock = ~i_clock;

  cwd_top #(.OUT_W(8), .SAFE_VALUE(8'h00)) i_cwd_top (
    .i_clock(i_clock), .i_rst(i_rst), .i_reg_req(req), .o_reg_rsp(rsp),
    .i_pd_exchange_done(pd_pulse), .i_local_access(li_pulse),
    .i_comm_state(st_in), .o_comm_state(st_out),
    .i_app_outputs(app), .o_outputs(outs), .o_sm_expired(sm_exp), .o_li_expired(li_exp));
  cwd_partner i_cwd_partner_pd (.i_clock(i_clock), .i_run(pd_run), .i_kick(pd_kick),
    .o_pulse(pd_pulse));
  cwd_partner i_cwd_partner_li (.i_clock(i_clock), .i_run(1'b0), .i_kick(li_kick),
    .o_pulse(li_pulse));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction

  // Non-blocking, so a check at the same step still sees what the design sampled
  always @(posedge i_clock) begin
    #1;
    if (rnd_on) begin
      seed = xorshift(seed);
      app <= seed[7:0];
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req = '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
    @(posedge i_clock) #1;
    req = '0;
    @(posedge i_clock) #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    req = '{wr:1'b0, rd:1'b1, addr:a, wdata:16'h0000};
    @(posedge i_clock) #1;
    req = '0;
    chk({15'h0, rsp.rvalid}, 16'h0001, "read valid");
    chk(rsp.rdata, exp, "read data");
    @(posedge i_clock) #1;
  endtask

  // One watchdog tick is multiplier plus two base ticks of 1.6 clocks on average
  task automatic measure(input int ticks, input int mult, input bit sm);
    int exp_c;
    exp_c = ticks * (mult + 2) * 8 / 5;
    if (sm) pd_kick = 1'b1;
    else li_kick = 1'b1;
    @(posedge i_clock) #1;
    pd_kick = 1'b0;
    li_kick = 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
    n = 3;
    while ((sm ? sm_exp : li_exp) !== 1'b1 && n < 300) begin
      @(posedge i_clock) #1;
      n++;
    end
    chk(16'(n >= exp_c && n <= exp_c + 7), 16'h0001, "expiry time");
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(25 * 4000);
    n_errors++;
    $display("wrong value at %0t: run hung", $time);
    report_and_stop;
  end

  initial begin
    repeat (6) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    rd(16'h0400, 16'h09c2);
    rd(16'h0420, 16'h03e8);
    rd(16'h0410, 16'h03e8);
    rd(16'h0500, 16'h0000);
    // First settings go in after the defaults are read back, as the master would do it; later steps rewrite them
    wr(16'h0400, 16'h0000);
    wr(16'h0420, 16'h0005);
    rd(16'h0420, 16'h0005);
    measure(5, 0, 1'b1);
    chk({8'h00, outs}, 16'h0000, "safe outputs");
    chk({13'h0, st_out}, {13'h0, cwd_pkg::CWD_ST_RUNNING_STATE}, "state");
    pd_run = 1'b1;
    repeat (10) @(posedge i_clock);
    n = 0;
    repeat (100) begin
      @(posedge i_clock) #1;
      n += int'(sm_exp !== 1'b0);
      chk({8'h00, outs}, {8'h00, app}, "outputs follow");
    end
    chk(16'(n), 16'h0000, "restarted watchdog");
    rnd_on = 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
    chk({8'h00, outs}, {8'h00, app}, "outputs follow");
    pd_run = 1'b0;
    repeat (40) @(posedge i_clock);
    #1;
    chk({15'h0, sm_exp}, 16'h0001, "expired");
    chk({8'h00, outs}, 16'h0000, "safe outputs");
    st_in = cwd_pkg::CWD_ST_SAFEOP;
    wr(16'h0420, 16'h0000);
    chk({13'h0, st_out}, {13'h0, cwd_pkg::CWD_ST_SAFEOP}, "state follows");
    st_in = cwd_pkg::CWD_ST_RUNNING_STATE;
    repeat (3) @(posedge i_clock);
    n = 0;
    repeat (60) begin
      @(posedge i_clock) #1;
      n += int'(sm_exp !== 1'b0);
    end
    chk(16'(n), 16'h0000, "disabled watchdog");
    chk({8'h00, outs}, {8'h00, app}, "outputs kept");
    wr(16'h0410, 16'h0003);
    measure(3, 0, 1'b0);
    @(posedge i_clock) #1;
    chk({8'h00, outs}, 16'h0000, "safe outputs");
    rd(16'h0440, 16'h0002);
    // A non-zero multiplier stretches every watchdog tick
    wr(16'h0400, 16'h0001);
    measure(3, 1, 1'b0);
    wr(16'h0410, 16'hffff);
    rd(16'h0410, 16'hffff);
    report_and_stop;
  end
endmodule // cwd_top_tb
